// *** hw/spc_pkg.sv ***
/*
  constants, types and helper functions for the standby pin configuration block.
  assumes one 50 MHz system clock and an 8-bit register port.
*/
// How it works
// RL1 - input-only pins read all zero; output-only pins read bits 7-4 as zero
// RL2 - bit 5 polarity: zero falling edge or low level, one rising or high
// RL3 - bit 4 trigger type: zero edge detection, one level detection
// RL4 - bit 3 lock is set-only; only the power-up reset clears it
// RL5 - while a pin is locked, writes to its bits 2-0 are ignored
// RL6 - a locked pin keeps its driven output value; data-out writes are ignored
// RL7 - bit 2 turns the weak pull-up on, default on
// RL8 - bit 1 output buffer: zero open-drain, one push-pull
// RL9 - bit 0 enables the driver on bidirectional pins; input sampling unaffected
// RL10 - output-only pins read bit 0 as one, writes to it ignored
// RL11 - bit 6 routes the input through a 15 ms stability debouncer, default on
// RL12 - event bits serve bidir and event-input pins; bits 0-3 bidir and output-only
// RL13 - one shared address; port select and pin select choose the pin
// RL14 - reserved bits read zero and ignore writes for every pin class
// RL15 - pin inputs pass a two-flop synchroniser before any detection
`default_nettype none
package spc_pkg;

  // register map
  localparam logic [7:0] SPC_CFG_OFFSET    = 8'h14;

  // field positions inside the configuration byte
  localparam int         SPC_BIT_OE        = 0;
  localparam int         SPC_BIT_OTYPE     = 1;
  localparam int         SPC_BIT_PULLUP    = 2;
  localparam int         SPC_BIT_LOCK      = 3;
  localparam int         SPC_BIT_ETYPE     = 4;
  localparam int         SPC_BIT_EPOL      = 5;
  localparam int         SPC_BIT_DEBOUNCE  = 6;

  // values after reset
  localparam logic [2:0] SPC_EVT_RST       = 3'h4;
  localparam logic [3:0] SPC_CTL_RST_BIDIR = 4'h4;
  localparam logic [3:0] SPC_CTL_RST_OUT   = 4'h5;
  localparam logic       SPC_DRV_RST       = 1'b1;
  localparam logic       SPC_PIN_RST       = 1'b1;

  // pin counts
  localparam int         SPC_NUM_EVT       = 8;
  localparam int         SPC_NUM_BIDIR     = 6;
  localparam int         SPC_NUM_CTL       = 8;
  localparam int         SPC_NUM_PINS      = 12;

  // debounce time
  localparam int         SPC_DEBOUNCE_US   = 15000;
  localparam int         SPC_CLK_KHZ       = 50000;
  localparam int         SPC_DEBOUNCE_CYC  = SPC_DEBOUNCE_US * SPC_CLK_KHZ / 1000;
  localparam int         SPC_DEB_W         = 20;

  typedef enum logic [3:0] {
    SPC_CLS_BIDIR   = 4'b0001,
    SPC_CLS_EVTIN   = 4'b0010,
    SPC_CLS_OUTONLY = 4'b0100,
    SPC_CLS_NONE    = 4'b1000
  } spc_class_t;

  // pin class from port select and pin select
  function automatic spc_class_t spc_class(input logic port, input logic [2:0] pin);
    spc_class_t cls;
    cls = SPC_CLS_NONE;
    if (!port)
    begin
      cls = (pin < 3'h6) ? SPC_CLS_BIDIR : SPC_CLS_EVTIN;
    end
    else if (pin < 3'h2)
    begin
      cls = SPC_CLS_OUTONLY;
    end
    return cls;
  endfunction

  // slot in the output-control store: bidir pins 0-5, output-only pins 6-7
  function automatic logic [2:0] spc_ctl_slot(input logic port, input logic [2:0] pin);
    logic [2:0] slot;
    slot = port ? (3'h6 + {2'h0, pin[0]}) : pin;
    return slot;
  endfunction

endpackage
`default_nettype wire

// *** hw/spc_debounce.sv ***
/*
  stability debouncer for one synchronised pin level.
  assumes its input is already in the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_debounce #(
  parameter int unsigned STABLE_CYCLES = spc_pkg::SPC_DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  // level
  input  wire logic level_in,
  output logic      level_out
);

  localparam logic [spc_pkg::SPC_DEB_W-1:0] LAST =
    spc_pkg::SPC_DEB_W'(STABLE_CYCLES - 1);

  logic [spc_pkg::SPC_DEB_W-1:0] cnt_r;
  logic                          level_r;
  wire                           differs = level_in != level_r;
  wire                           done    = differs && (cnt_r == LAST);

  // any bounce restarts the count, so both edges wait the full time
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_r   <= '0;
      level_r <= spc_pkg::SPC_PIN_RST;
    end
    else
    begin
      cnt_r   <= (differs && !done) ? cnt_r + 1'b1 : '0; // see RL11
      level_r <= done ? level_in : level_r;
    end
  end

  assign level_out = level_r;

endmodule
`default_nettype wire

// *** hw/spc_event_detect.sv ***
/*
  edge or level event detector for one pin.
  assumes raw and debounced levels are both synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_event_detect (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  // levels
  input  wire logic raw_in,
  input  wire logic debounced_in,
  // configuration
  input  wire logic debounce_en_in,
  input  wire logic polarity_in,
  input  wire logic level_mode_in,
  // result
  output logic      event_out
);

  wire  src    = debounce_en_in ? debounced_in : raw_in;   // see RL11
  wire  active = polarity_in ? src : ~src;                 // see RL2
  logic prev_r;
  logic event_r;
  // edges compare the level itself, so a polarity change alone raises no event
  wire  edge_hit = polarity_in ? (src & ~prev_r) : (~src & prev_r); // see RL15

  // prev starts at the idle pin level so reset gives no false edge
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      prev_r  <= spc_pkg::SPC_PIN_RST;
      event_r <= 1'b0;
    end
    else
    begin
      prev_r  <= src;
      event_r <= level_mode_in ? active : edge_hit;        // see RL3
    end
  end

  assign event_out = event_r;

endmodule
`default_nettype wire

// *** hw/spc_standby_pin_config.sv ***
/*
  per-pin configuration of the standby pin port: shared configuration
  register, lock, output drivers, pull-ups and event detection.
  assumes pin select and data-out come from same-clock logic; pins are async.
  pins: 0-5 bidirectional, 6-7 event inputs, 8-9 output-only, 10-11 input-only.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_standby_pin_config #(
  parameter int unsigned DEBOUNCE_CYCLES = spc_pkg::SPC_DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic                              clock_in,
  input  wire logic                              reset_n_in,
  input  wire logic                              soft_reset_in,
  // pin selection
  input  wire logic                              sel_port_in,
  input  wire logic [2:0]                        sel_pin_in,
  // register port
  input  wire logic [7:0]                        addr_in,
  input  wire logic [7:0]                        wdata_in,
  input  wire logic                              wr_in,
  input  wire logic                              rd_in,
  output logic      [7:0]                        rdata_out,
  // data-out value per driven pin
  input  wire logic [spc_pkg::SPC_NUM_CTL-1:0]   standby_data_out_in,
  // pins
  input  wire logic [spc_pkg::SPC_NUM_PINS-1:0]  pin_in,
  output logic      [spc_pkg::SPC_NUM_PINS-1:0]  pin_level_out,
  output logic      [spc_pkg::SPC_NUM_CTL-1:0]   pin_out,
  output logic      [spc_pkg::SPC_NUM_CTL-1:0]   pin_oe_out,
  output logic      [spc_pkg::SPC_NUM_CTL-1:0]   pullup_en_out,
  output logic      [spc_pkg::SPC_NUM_CTL-1:0]   lock_out,
  // events
  output logic      [spc_pkg::SPC_NUM_EVT-1:0]   debounced_out,
  output logic      [spc_pkg::SPC_NUM_EVT-1:0]   event_out
);

  localparam int NCTL = spc_pkg::SPC_NUM_CTL;
  localparam int NEVT = spc_pkg::SPC_NUM_EVT;
  localparam int NPIN = spc_pkg::SPC_NUM_PINS;

  // configuration store
  logic [2:0]      evt_r   [NEVT];
  logic [2:0]      evt_nxt [NEVT];
  logic [3:0]      ctl_r   [NCTL];
  logic [3:0]      ctl_nxt [NCTL];
  logic [7:0]      rdata_r;
  logic [NCTL-1:0] drv_r;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;

  // selection decode
  spc_pkg::spc_class_t sel_cls;
  wire logic [2:0] sel_slot;
  wire logic       cfg_hit;
  wire logic       cfg_wr;
  wire logic       cfg_rd;
  wire logic       has_evt;
  wire logic       has_ctl;
  wire logic       is_out;
  wire logic [2:0] rd_evt;
  wire logic [3:0] rd_ctl;
  wire logic [7:0] cfg_val;

  assign sel_cls  = spc_pkg::spc_class(sel_port_in, sel_pin_in);       // see RL13
  assign sel_slot = spc_pkg::spc_ctl_slot(sel_port_in, sel_pin_in);
  assign cfg_hit  = addr_in == spc_pkg::SPC_CFG_OFFSET;                 // see RL13
  assign cfg_wr   = wr_in && cfg_hit;
  assign cfg_rd   = rd_in && cfg_hit;
  assign has_evt  = (sel_cls == spc_pkg::SPC_CLS_BIDIR) ||
                    (sel_cls == spc_pkg::SPC_CLS_EVTIN);                // see RL12
  assign has_ctl  = (sel_cls == spc_pkg::SPC_CLS_BIDIR) ||
                    (sel_cls == spc_pkg::SPC_CLS_OUTONLY);              // see RL12
  assign is_out   = sel_cls == spc_pkg::SPC_CLS_OUTONLY;

  // read value; input-only and absent pins read all zero
  assign rd_evt  = has_evt ? evt_r[sel_pin_in] : 3'h0;                  // see RL1
  assign rd_ctl  = has_ctl ? ctl_r[sel_slot] : 4'h0;                    // see RL1
  assign cfg_val = {1'b0, rd_evt, rd_ctl};                              // see RL14

  // event field update; the lock does not cover these bits
  always_comb
  begin
    for (int i = 0; i < NEVT; i++)
    begin
      evt_nxt[i] = evt_r[i];
      if (soft_reset_in)
      begin
        evt_nxt[i] = spc_pkg::SPC_EVT_RST;
      end
      if (cfg_wr && !sel_port_in && (sel_pin_in == 3'(i)))
      begin
        evt_nxt[i] = wdata_in[spc_pkg::SPC_BIT_DEBOUNCE:spc_pkg::SPC_BIT_ETYPE];
      end
    end
  end

  // output control update; a locked slot keeps every bit
  always_comb
  begin
    for (int i = 0; i < NCTL; i++)
    begin
      ctl_nxt[i] = ctl_r[i];
      if (soft_reset_in && !ctl_r[i][spc_pkg::SPC_BIT_LOCK])
      begin
        ctl_nxt[i] = (i >= spc_pkg::SPC_NUM_BIDIR) ? spc_pkg::SPC_CTL_RST_OUT :
                                                     spc_pkg::SPC_CTL_RST_BIDIR;
      end
      if (cfg_wr && has_ctl && (sel_slot == 3'(i)) &&
          !ctl_r[i][spc_pkg::SPC_BIT_LOCK])                             // see RL5
      begin
        ctl_nxt[i] = wdata_in[3:0];                                     // see RL4
        if (is_out)
        begin
          ctl_nxt[i][spc_pkg::SPC_BIT_OE] = 1'b1;                       // see RL10
        end
      end
    end
  end

  // power-up reset is the only path that clears a lock
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < NEVT; i++)
      begin
        evt_r[i] <= spc_pkg::SPC_EVT_RST;
      end
      for (int i = 0; i < NCTL; i++)
      begin
        ctl_r[i] <= (i >= spc_pkg::SPC_NUM_BIDIR) ? spc_pkg::SPC_CTL_RST_OUT :
                                                    spc_pkg::SPC_CTL_RST_BIDIR; // see RL4
      end
    end
    else
    begin
      evt_r <= evt_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= cfg_rd ? cfg_val : 8'h00;                              // see RL14
    end
  end

  assign rdata_out = rdata_r;

  // driven value follows data-out until locked, then freezes
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      drv_r <= {NCTL{spc_pkg::SPC_DRV_RST}};
    end
    else
    begin
      for (int i = 0; i < NCTL; i++)
      begin
        drv_r[i] <= ctl_r[i][spc_pkg::SPC_BIT_LOCK] ? drv_r[i] :
                                                      standby_data_out_in[i]; // see RL6
      end
    end
  end

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sync1_r <= {NPIN{spc_pkg::SPC_PIN_RST}};
      sync2_r <= {NPIN{spc_pkg::SPC_PIN_RST}};
    end
    else
    begin
      sync1_r <= pin_in;                                                // see RL15
      sync2_r <= sync1_r;                                               // see RL15
    end
  end

  // sampling ignores the driver state
  assign pin_level_out = sync2_r;                                       // see RL9

  genvar g;
  generate
    for (g = 0; g < NCTL; g++)
    begin : g_drv
      wire logic en   = ctl_r[g][spc_pkg::SPC_BIT_OE];                  // see RL9
      wire logic push = ctl_r[g][spc_pkg::SPC_BIT_OTYPE];
      // open-drain only ever drives low; a high comes from the pull-up
      assign pin_out[g]       = drv_r[g];
      assign pin_oe_out[g]    = en && (push || !drv_r[g]);              // see RL8
      assign pullup_en_out[g] = ctl_r[g][spc_pkg::SPC_BIT_PULLUP];      // see RL7
      assign lock_out[g]      = ctl_r[g][spc_pkg::SPC_BIT_LOCK];
    end

    for (g = 0; g < NEVT; g++)
    begin : g_evt
      spc_debounce #(
        .STABLE_CYCLES (DEBOUNCE_CYCLES)
      ) u_deb (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .level_in   (sync2_r[g]),
        .level_out  (debounced_out[g])
      );

      spc_event_detect u_det (
        .clock_in       (clock_in),
        .reset_n_in     (reset_n_in),
        .raw_in         (sync2_r[g]),
        .debounced_in   (debounced_out[g]),
        .debounce_en_in (evt_r[g][2]),                                  // see RL11
        .polarity_in    (evt_r[g][1]),                                  // see RL2
        .level_mode_in  (evt_r[g][0]),                                  // see RL3
        .event_out      (event_out[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// *** verification/spc_standby_pin_config_checker.sv ***
/*
  port checker for the standby pin configuration block.
  assumes one clock, async active-low reset, pins high during reset.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_checker (
  // clock and reset
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  // register port
  input wire logic        sel_port_in,
  input wire logic [2:0]  sel_pin_in,
  input wire logic [7:0]  addr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  // pins
  input wire logic [11:0] pin_in,
  input wire logic [11:0] pin_level_out,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_out,
  input wire logic [7:0]  pullup_en_out,
  input wire logic [7:0]  lock_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence cfg_rd;
    rd_in && addr_in == spc_pkg::SPC_CFG_OFFSET;
  endsequence
  sequence in_only_rd;
    cfg_rd ##0 (sel_port_in && sel_pin_in >= 3'h2);
  endsequence
  sequence out_only_rd;
    cfg_rd ##0 (sel_port_in && sel_pin_in < 3'h2);
  endsequence
  AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (rd_in && addr_in != 8'h14 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_IN_ONLY: assert property (in_only_rd |=> rdata_out == 8'h00)
    else $error("input-only pin read not zero");
  AST_OUT_ONLY: assert property (out_only_rd |=> rdata_out[7:4] == 4'h0 && rdata_out[0])
    else $error("output-only pin read wrong");
  AST_SYNC: assert property (pin_level_out == $past(pin_in, 2))
    else $error("pin level not two cycles behind pin");
  AST_LOCK_STICKY: assert property (($past(lock_out) & ~lock_out) == 8'h00)
    else $error("lock cleared without reset");
  AST_PULLUP_LOCK: assert property (((pullup_en_out ^ $past(pullup_en_out)) & $past(lock_out)) == 8'h00)
    else $error("pull-up changed on locked pin");
  AST_DRV_FROZEN: assert property (((pin_out ^ $past(pin_out)) & $past(lock_out)) == 8'h00)
    else $error("driven value changed on locked pin");
  AST_OUT_OE: assert property ((~pin_out[7:6] & ~pin_oe_out[7:6]) == 2'b00)
    else $error("output-only driver off while driving low");
endmodule
bind spc_standby_pin_config spc_checker u_chk (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .sel_port_in(sel_port_in),
  .sel_pin_in(sel_pin_in), .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .pin_in(pin_in), .pin_level_out(pin_level_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out), .lock_out(lock_out)
);
`default_nettype wire

// *** verification/spc_testbench.sv ***
/*
  self-checking bench for the standby pin configuration block.
  assumes debounce shortened to 8 cycles; undriven pins rest high.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] OFF = spc_pkg::SPC_CFG_OFFSET;
  logic        clock_in;
  logic        reset_n_in;
  logic        soft_reset_in;
  logic        sel_port_in;
  logic [2:0]  sel_pin_in;
  logic [7:0]  addr_in, wdata_in, rdata_out, standby_data_out_in;
  logic        wr_in, rd_in;
  logic [11:0] ext_pin, pin_level_out;
  wire  [11:0] pin_w;
  logic [7:0]  pin_out, pin_oe_out, pullup_en_out, lock_out, debounced_out, event_out;
  int          n_mismatch = 0;
  int          check_count = 0;

  // driven pins resolve against the outside level
  assign pin_w[5:0]   = (pin_oe_out[5:0] & pin_out[5:0]) | (~pin_oe_out[5:0] & ext_pin[5:0]);
  assign pin_w[7:6]   = ext_pin[7:6];
  assign pin_w[9:8]   = (pin_oe_out[7:6] & pin_out[7:6]) | (~pin_oe_out[7:6] & ext_pin[9:8]);
  assign pin_w[11:10] = ext_pin[11:10];

  spc_standby_pin_config #(.DEBOUNCE_CYCLES(8)) dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .soft_reset_in(soft_reset_in),
    .sel_port_in(sel_port_in), .sel_pin_in(sel_pin_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .standby_data_out_in(standby_data_out_in), .pin_in(pin_w),
    .pin_level_out(pin_level_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .pullup_en_out(pullup_en_out), .lock_out(lock_out),
    .debounced_out(debounced_out), .event_out(event_out)
  );

  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    {sel_port_in, sel_pin_in} <= p;
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] p, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    {sel_port_in, sel_pin_in} <= p;
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask

  task automatic t_defaults();
    logic [7:0] e;
    for (int i = 0; i < 16; i++)
    begin
      e = (i < 6) ? 8'h44 : (i < 8) ? 8'h40 : (i < 10) ? 8'h05 : 8'h00;
      rd(4'(i), OFF, e);
    end
    chk(pin_oe_out, 8'h00);
    chk(pullup_en_out, 8'hff);
    chk(lock_out, 8'h00);
  endtask
  task automatic t_fields();
    wr(4'h3, OFF, 8'h01);
    cyc(1);
    chk({pullup_en_out[3], pin_oe_out[3]}, 2'b00);
    @(posedge clock_in);
    standby_data_out_in <= 8'hf7;
    cyc(2);
    chk(pin_oe_out[3], 1'b1);
    cyc(3);
    chk(pin_level_out[3], 1'b0);
    wr(4'h4, OFF, 8'h03);
    cyc(1);
    chk(pin_oe_out[4], 1'b1);
    wr(4'h2, OFF, 8'hff);
    rd(4'h2, OFF, 8'h7f);
  endtask
  task automatic t_lock();
    chk(lock_out[2], 1'b1);
    @(posedge clock_in);
    standby_data_out_in <= 8'hf3;
    wr(4'h2, OFF, 8'h00);
    rd(4'h2, OFF, 8'h0f);
    chk({pin_out[2], pullup_en_out[2]}, 2'b11);
    @(posedge clock_in);
    soft_reset_in <= 1'b1;
    @(posedge clock_in);
    soft_reset_in <= 1'b0;
    rd(4'h2, OFF, 8'h4f);
    rd(4'h3, OFF, 8'h44);
  endtask
  task automatic t_outonly();
    wr(4'h8, OFF, 8'hf2);
    rd(4'h8, OFF, 8'h03);
    chk(pin_oe_out[6], 1'b1);
    wr(4'h9, 8'h15, 8'hff);
    rd(4'h9, OFF, 8'h05);
    wr(4'ha, OFF, 8'hff);
    rd(4'ha, OFF, 8'h00);
    rd(4'hf, OFF, 8'h00);
    rd(4'h8, 8'h15, 8'h00);
  endtask
  task automatic t_event();
    int c;
    wr(4'h6, OFF, 8'h20);
    cyc(1);
    chk(event_out[6], 1'b0);
    @(posedge clock_in);
    ext_pin[6] <= 1'b0;
    cyc(5);
    chk(event_out[6], 1'b0);
    @(posedge clock_in);
    ext_pin[6] <= 1'b1;
    cyc(3);
    chk(event_out[6], 1'b1);
    cyc(1);
    chk(event_out[6], 1'b0);
    wr(4'h6, OFF, 8'h10);
    cyc(2);
    chk(event_out[6], 1'b0);
    @(posedge clock_in);
    ext_pin[6] <= 1'b0;
    cyc(8);
    chk(event_out[6], 1'b1);
    wr(4'h6, OFF, 8'h60);
    @(posedge clock_in);
    ext_pin[6] <= 1'b1;
    cyc(6);
    chk(event_out[6], 1'b0);
    for (c = 0; c < 12 && event_out[6] !== 1'b1; c++)
      cyc(1);
    chk({debounced_out[6], event_out[6]}, 2'b11);
    // 2 sync + 8 stable + 1 detect edges, 6 already waited
    chk(12'(c), 12'h005);
  endtask
  task automatic t_reset();
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd(4'h2, OFF, 8'h44);
    chk(lock_out, 8'h00);
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // whole run is about 130 cycles
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    reset_n_in = 1'b0;
    soft_reset_in = 1'b0;
    {sel_port_in, sel_pin_in, addr_in, wdata_in, wr_in, rd_in} = '0;
    standby_data_out_in = 8'hff;
    ext_pin = 12'hfff;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_defaults();
    t_fields();
    t_lock();
    t_outonly();
    t_event();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
